// >>> rtl/rcfr_divider.sv
// iterative restoring divider, restarted continuously by its user
module rcfr_divider import rcfr_pkg::*; #(
	parameter int W = RCFR_RW,
	parameter int DW = RCFR_CW
) (
	// clock and reset
	input logic sys_clk,
	input logic rstn,
	input logic clkEn,
	// operands
	input logic start,
	input logic [W-1:0] dividend,
	input logic [DW-1:0] divisor,
	// result
	output logic busy,
	output logic [W-1:0] quotient
);
	localparam int NW = $clog2(W + 1);
	typedef struct packed {
		logic busy;
		logic [NW-1:0] cnt;
		logic [DW:0] rem;
		logic [W-1:0] dvd;
		logic [DW-1:0] dvs;
		logic [W-1:0] result;
	} rcfr_div_s;
	rcfr_div_s q, d;
	logic [DW:0] trial;

	always_comb begin
		d = q;
		trial = {q.rem[DW-1:0], q.dvd[W-1]};
		if (!q.busy && start) begin
			d.busy = 1'b1;
			d.cnt = NW'(W);
			d.rem = '0;
			d.dvd = dividend;
			// zero stations would divide by zero: treat as one
			d.dvs = (divisor == '0) ? DW'(1) : divisor;
		end else if (q.busy) begin
			d.dvd = {q.dvd[W-2:0], 1'b0};
			if (trial >= {1'b0, q.dvs}) begin
				d.rem = trial - {1'b0, q.dvs};
				d.dvd[0] = 1'b1;
			end else
				d.rem = trial;
			d.cnt = q.cnt - NW'(1);
			if (q.cnt == NW'(1)) begin
				d.busy = 1'b0;
				d.result = d.dvd;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			q <= '0;
		else if (clkEn)
			q <= d;
	end

	assign busy = q.busy;
	assign quotient = q.result;
endmodule: rcfr_divider

// >>> rtl/rcfr_fair_rate.sv
// congestion detection and fair rate calculation for one ring station
module rcfr_fair_rate import rcfr_pkg::*; (
	// clock, reset, enable
	input logic sys_clk,
	input logic rstn,
	input logic clkEn,
	// avalon-mm slave
	input logic [7:0] avsAddress,
	input logic avsRead,
	input logic avsWrite,
	input logic [31:0] avsWritedata,
	input logic [3:0] avsByteenable,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	// static configuration
	input logic conservativeMode,
	input logic oneQueueVariant,
	// data path
	input logic byteAdded,
	input logic byteForwarded,
	input logic beyondCongestion,
	input logic nonA0Byte,
	input logic [RCFR_QW-1:0] transitQueueDepth,
	input logic classBDelayExpired,
	input logic classCDelayExpired,
	// fairness message side
	input logic agingTick,
	input logic [RCFR_FW-1:0] advertisedFairRate,
	input logic [RCFR_CW-1:0] activeStationCount,
	// results
	output logic localCongestionFlag,
	output logic [RCFR_RW-1:0] ownFairRate,
	output logic [RCFR_RW-1:0] scaledOwnFairRate,
	output logic [RCFR_RW-1:0] permittedRate,
	output logic [RCFR_RW-1:0] permittedRateTowardCongestion,
	output logic [RCFR_RW-1:0] scaledFilteredFwdCongRate
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		rcfr_state_e st;
		logic ctrlRun;
		logic [RCFR_RW-1:0] lineRate;
		logic [RCFR_RW-1:0] resvRate;
		logic [RCFR_CW-1:0] station_a;
		logic [RCFR_QW-1:0] qCap;
		logic [RCFR_RW-1:0] unres;
		logic [RCFR_QW-1:0] qHi;
		logic [RCFR_QW-1:0] qLo;
		logic [RCFR_RW-1:0] rateHi;
		logic [RCFR_RW-1:0] rateLo;
		logic flag;
		logic [RCFR_RW-1:0] own;
		logic [RCFR_RW-1:0] scaledOwn;
		logic [RCFR_RW-1:0] permit;
		logic [RCFR_RW-1:0] permitCong;
		logic [RCFR_RW-1:0] scaledFwCong;
		logic [RTT_CW-1:0] rtt;
		logic waitReq;
		logic [31:0] rdata;
	} rcfr_core_s;

	rcfr_core_s q, d;

	logic ageTick;
	logic isCong;
	logic hiCond;
	logic loCond;
	logic rttDone;
	logic [RCFR_RW:0] addFwSum;
	logic [RCFR_RW-1:0] unresNew;
	logic [RCFR_RW-1:0] shareRate;
	logic divBusy;
	logic [RCFR_IW-1:0] chInc [CH_NUM];
	logic [RCFR_RW-1:0] chRaw [CH_NUM];
	logic [RCFR_RW-1:0] chFilt [CH_NUM];
	logic [RCFR_RW-1:0] chNext [CH_NUM];

	// ****************************************************************
	// byte counters and filters
	// ****************************************************************
	always_comb begin
		chInc[CH_ADD] = RCFR_IW'(byteAdded);
		chInc[CH_ADDC] = RCFR_IW'(byteAdded && beyondCongestion);
		chInc[CH_FW] = RCFR_IW'(byteForwarded);
		chInc[CH_FWC] = RCFR_IW'(byteForwarded && beyondCongestion);
		// a non-A0 add and a non-A0 forward in one cycle both count as transmitted
		chInc[CH_XMIT] = RCFR_IW'(byteAdded && nonA0Byte)
			+ RCFR_IW'(byteForwarded && nonA0Byte);
	end

	for (genvar i = 0; i < CH_NUM; i++) begin : gChan
		rcfr_rate_chan #(.W(RCFR_RW)) uChan (
			.sys_clk(sys_clk),
			.rstn(rstn),
			.clkEn(clkEn),
			.incr(chInc[i]),
			.tick(ageTick),
			.rawCount(chRaw[i]),
			.filtRate(chFilt[i]),
			.filtNext(chNext[i])
		);
	end

	// fair share runs in the background; inputs are quasi-static, so
	// the result can lag a change by up to two divisions
	rcfr_divider #(.W(RCFR_RW), .DW(RCFR_CW)) uShare (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.clkEn(clkEn),
		.start(1'b1),
		.dividend(q.unres),
		.divisor(activeStationCount),
		.busy(divBusy),
		.quotient(shareRate)
	);

	// ****************************************************************
	// congestion conditions
	// ****************************************************************
	always_comb begin
		ageTick = agingTick && q.ctrlRun && (q.st != ST_INIT);
		unresNew = q.lineRate - q.resvRate;
		addFwSum = (RCFR_RW+1)'(chRaw[CH_ADD]) + (RCFR_RW+1)'(chRaw[CH_FW]);
		hiCond = (addFwSum > (RCFR_RW+1)'(q.rateHi))
			|| (transitQueueDepth > q.qHi);
		loCond = (addFwSum < (RCFR_RW+1)'(q.rateLo))
			|| (transitQueueDepth < q.qLo);
		rttDone = (q.rtt >= RTT_TICKS);
		if (!oneQueueVariant)
			isCong = (chFilt[CH_XMIT] > q.unres)
				|| (transitQueueDepth > q.qLo);
		else
			isCong = (chFilt[CH_XMIT] > q.unres)
				|| (chFilt[CH_XMIT] > q.rateLo)
				|| classBDelayExpired || classCDelayExpired;
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = q;
		// bus: every request sees one wait cycle, then its answer
		d.waitReq = !((avsRead || avsWrite) && q.waitReq);
		if (avsRead && q.waitReq) begin
			case ({avsAddress[7:2], 2'b00})
				OFS_CTRL: d.rdata = {31'h0, q.ctrlRun};
				OFS_LINE: d.rdata = q.lineRate;
				OFS_RESV: d.rdata = q.resvRate;
				OFS_STATION_A: d.rdata = {16'h0, q.station_a};
				OFS_QCAP: d.rdata = {16'h0, q.qCap};
				OFS_STATUS: d.rdata = {28'h0, q.flag, q.st};
				OFS_OWN: d.rdata = q.own;
				OFS_PERMIT: d.rdata = q.permit;
				OFS_PCONG: d.rdata = q.permitCong;
				default: d.rdata = 32'h0;
			endcase
		end
		if (avsWrite && !q.waitReq) begin
			for (int b = 0; b < 4; b++) begin
				if (avsByteenable[b]) begin
					case ({avsAddress[7:2], 2'b00})
						OFS_CTRL: if (b == 0) d.ctrlRun = avsWritedata[0];
						OFS_LINE: d.lineRate[8*b +: 8] = avsWritedata[8*b +: 8];
						OFS_RESV: d.resvRate[8*b +: 8] = avsWritedata[8*b +: 8];
						OFS_STATION_A: if (b < 2) begin
							d.station_a[8*b +: 8] = avsWritedata[8*b +: 8];
						end
						OFS_QCAP: if (b < 2) begin
							d.qCap[8*b +: 8] = avsWritedata[8*b +: 8];
						end
						default: ;
					endcase
				end
			end
		end

		// fairness state machine; rows are tried in order
		case (q.st)
			ST_INIT: begin
				d.unres = unresNew;
				d.qHi = q.qCap / RCFR_QW'(Q_HI_DIV);
				d.qLo = q.qCap / RCFR_QW'(Q_LO_DIV);
				d.rateHi = rcfr_scale(unresNew, RATE_HI_NUM);
				d.rateLo = rcfr_scale(unresNew, RATE_LO_NUM);
				d.flag = 1'b0;
				d.own = unresNew;
				d.permit = RATE_CEILING;
				if (q.ctrlRun)
					d.st = ST_UNCONGESTED;
			end
			ST_UNCONGESTED: begin
				if (!q.ctrlRun)
					d.st = ST_INIT;
				else if (ageTick && !conservativeMode) begin
					if (isCong) begin
						d.flag = 1'b1;
						d.own = chFilt[CH_ADD];
						d.st = ST_CONGESTED;
					end
					// a calm tick falls through to the shared updates
				end else if (ageTick) begin
					if (isCong) begin
						d.own = RCFR_RW'(shareRate * q.station_a);
						d.flag = 1'b1;
						d.permit = d.own;
						d.rtt = '0;
						d.st = ST_CONGESTED;
					end else
						d.permit = rcfr_ramp(q.permit, RATE_CEILING);
				end
			end
			ST_CONGESTED: begin
				if (!q.ctrlRun)
					d.st = ST_INIT;
				else if (ageTick && !conservativeMode) begin
					if (!isCong) begin
						d.flag = 1'b0;
						d.own = q.unres;
						d.st = ST_UNCONGESTED;
					end else begin
						d.flag = 1'b1;
						d.own = chFilt[CH_ADD];
					end
				end else if (ageTick) begin
					if (q.own >= q.unres) begin
						d.own = q.unres;
						d.flag = 1'b0;
						d.permit = rcfr_ramp(q.permit, RATE_CEILING);
						d.st = ST_UNCONGESTED;
					end else if (hiCond && rttDone) begin
						d.own = q.own - q.own / RCFR_RW'(RAMP_COEF);
						d.permit = d.own;
						d.rtt = '0;
					end else if (loCond && rttDone) begin
						d.own = rcfr_ramp(q.own, q.unres);
						if (d.own > q.unres)
							d.own = q.unres;
						d.permit = d.own;
						d.rtt = '0;
					end else
						d.permit = q.own;
				end
			end
			default: d.st = ST_INIT;
		endcase

		// round-trip interval count, saturating
		if (ageTick && (d.rtt == q.rtt) && !rttDone)
			d.rtt = q.rtt + RTT_CW'(1);

		// shared by every aging row of both tables
		if (ageTick) begin
			if (advertisedFairRate != FULL_RATE_CODE)
				d.permitCong = RCFR_RW'(advertisedFairRate)
					* RCFR_RW'(NORM_COEF);
			else
				d.permitCong = rcfr_ramp(q.permitCong, RATE_CEILING);
			d.scaledFwCong = chNext[CH_FWC] / RCFR_RW'(NORM_COEF);
		end
		d.scaledOwn = d.own / RCFR_RW'(NORM_COEF);
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.st <= ST_INIT;
			q.lineRate <= RST_LINE_RATE;
			q.resvRate <= RST_RESV_RATE;
			q.station_a <= RST_STATION_A;
			q.qCap <= RST_QUEUE_CAP;
			q.waitReq <= 1'b1;
		end else if (clkEn)
			q <= d;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign avsReaddata = q.rdata;
	assign avsWaitrequest = q.waitReq;
	assign localCongestionFlag = q.flag;
	assign ownFairRate = q.own;
	assign scaledOwnFairRate = q.scaledOwn;
	assign permittedRate = q.permit;
	assign permittedRateTowardCongestion = q.permitCong;
	assign scaledFilteredFwdCongRate = q.scaledFwCong;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	init_exit_a: assert property (
		clkEn && q.st == ST_INIT && q.ctrlRun |=>
		q.st == ST_UNCONGESTED && q.unres == $past(unresNew))
		else $error("init did not reach uncongested");
	// sampled rstn: the edge that releases reset still acts as reset
	queue_thr_a: assert property (
		rstn && clkEn && q.st == ST_INIT |=>
		q.qHi == $past(q.qCap) / 4 && q.qLo == $past(q.qCap) / 8)
		else $error("queue thresholds wrong");
	rate_thr_a: assert property (
		rstn && clkEn && q.st == ST_INIT |=>
		q.rateLo == rcfr_scale($past(unresNew), RATE_LO_NUM)
		&& q.rateHi == rcfr_scale($past(unresNew), RATE_HI_NUM))
		else $error("rate thresholds wrong");
	init_vals_a: assert property (
		rstn && clkEn && q.st == ST_INIT |=> !q.flag
		&& q.own == q.unres && q.permit == RATE_CEILING)
		else $error("init values wrong");
	aggr_enter_a: assert property (
		clkEn && ageTick && !conservativeMode && !oneQueueVariant
		&& q.st == ST_UNCONGESTED && transitQueueDepth > q.qLo |=>
		q.st == ST_CONGESTED && q.flag && q.own == $past(chFilt[CH_ADD]))
		else $error("deep queue did not congest");
	timer_cong_a: assert property (
		clkEn && ageTick && !conservativeMode && oneQueueVariant
		&& q.st == ST_UNCONGESTED
		&& (classBDelayExpired || classCDelayExpired) |=>
		q.st == ST_CONGESTED)
		else $error("expired timer did not congest");
	adv_rate_a: assert property (
		clkEn && ageTick && advertisedFairRate != FULL_RATE_CODE |=>
		q.permitCong == RCFR_RW'($past(advertisedFairRate)) * NORM_COEF)
		else $error("toward-congestion rate wrong");
	adv_ramp_a: assert property (
		clkEn && ageTick && advertisedFairRate == FULL_RATE_CODE |=>
		q.permitCong == rcfr_ramp($past(q.permitCong), RATE_CEILING))
		else $error("toward-congestion ramp wrong");
	aggr_leave_a: assert property (
		clkEn && ageTick && !conservativeMode && !isCong
		&& q.st == ST_CONGESTED |=>
		q.st == ST_UNCONGESTED && !q.flag && q.own == q.unres)
		else $error("aggressive release wrong");
	cons_leave_a: assert property (
		clkEn && ageTick && conservativeMode && q.st == ST_CONGESTED
		&& q.own >= q.unres |=> q.st == ST_UNCONGESTED && !q.flag)
		else $error("conservative release wrong");
	cons_down_a: assert property (
		clkEn && ageTick && conservativeMode && q.st == ST_CONGESTED
		&& q.own < q.unres && hiCond && rttDone |=>
		q.own == $past(q.own) - $past(q.own) / RAMP_COEF
		&& q.permit == q.own && q.rtt == 0)
		else $error("conservative ramp down wrong");
	scaled_own_a: assert property (
		q.scaledOwn == q.own / RCFR_RW'(NORM_COEF))
		else $error("scaled own rate stale");

	enter_cong_c: cover property (
		q.st == ST_UNCONGESTED ##1 q.st == ST_CONGESTED);
	leave_cong_c: cover property (
		q.st == ST_CONGESTED ##1 q.st == ST_UNCONGESTED);
	bus_read_c: cover property (avsRead && !avsWaitrequest);
endmodule: rcfr_fair_rate

// >>> rtl/rcfr_pkg.sv
// constants, types and helpers shared by the ring fairness rate block
// ********************************************************************
// Functional notes
// - init derives unreserved bandwidth, enters uncongested state
// - init queue thresholds: capacity/4 high, capacity/8 low
// - init rate thresholds: 0.95 and 0.8 unreserved
// - init clears flag, loads own, scaled, permitted rates
// - two-queue: congested on transmit rate or depth
// - one-queue: transmit rate, low threshold or timers
// - advertised non-full rate: toward-congestion rate scaled up
// - full-rate code: ramp toward-congestion rate to ceiling
// - aging tick low-pass filters all five counters
// - aging tick rescales filtered forward-congested rate
// - after filtering, raw counters decay by aging coefficient
// - aggressive uncongested with congestion: load add rate
// - aggressive uncongested calm tick: update, stay uncongested
// - aggressive congested calm tick: release, reload unreserved
// - aggressive congested persisting: reload from add rate
// - conservative entry: share times station_a, reset round trip
// - conservative calm tick: ramp permitted rate to ceiling
// - conservative own at unreserved: clamp, leave congestion
// - conservative overload after round trip: ramp own down
// - conservative underload after round trip: ramp own up
// - conservative otherwise: permitted follows own fair rate
// - raw counters count added, forwarded, transmitted bytes
// ********************************************************************
package rcfr_pkg;
	// widths
	localparam int RCFR_RW = 32;
	localparam int RCFR_QW = 16;
	localparam int RCFR_FW = 16;
	localparam int RCFR_CW = 16;
	localparam int RCFR_IW = 2;
	localparam int RTT_CW = 4;
	// coefficients and counts
	localparam int NORM_COEF = 16;
	localparam int RAMP_COEF = 64;
	localparam int LP_COEF = 64;
	localparam int AGE_COEF = 4;
	localparam int Q_HI_DIV = 4;
	localparam int Q_LO_DIV = 8;
	localparam int RATE_HI_NUM = 95;
	localparam int RATE_LO_NUM = 80;
	localparam int RATE_DEN = 100;
	localparam logic [RTT_CW-1:0] RTT_TICKS = 4'h8;
	localparam logic [RCFR_FW-1:0] FULL_RATE_CODE = 16'hffff;
	localparam logic [RCFR_RW-1:0] RATE_CEILING = 32'h0010_0000;
	// byte counter channels
	localparam int CH_ADD = 0;
	localparam int CH_ADDC = 1;
	localparam int CH_FW = 2;
	localparam int CH_FWC = 3;
	localparam int CH_XMIT = 4;
	localparam int CH_NUM = 5;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LINE = 8'h04;
	localparam logic [7:0] OFS_RESV = 8'h08;
	localparam logic [7:0] OFS_STATION_A = 8'h0c;
	localparam logic [7:0] OFS_QCAP = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_OWN = 8'h18;
	localparam logic [7:0] OFS_PERMIT = 8'h1c;
	localparam logic [7:0] OFS_PCONG = 8'h20;
	// reset values
	localparam logic [RCFR_RW-1:0] RST_LINE_RATE = 32'h000f_4240;
	localparam logic [RCFR_RW-1:0] RST_RESV_RATE = 32'h0000_0000;
	localparam logic [RCFR_CW-1:0] RST_STATION_A = 16'h0001;
	localparam logic [RCFR_QW-1:0] RST_QUEUE_CAP = 16'h1000;

	typedef enum logic [2:0] {
		ST_INIT = 3'b001,
		ST_UNCONGESTED = 3'b010,
		ST_CONGESTED = 3'b100
	} rcfr_state_e;

	function automatic logic [RCFR_RW-1:0] rcfr_scale(
		input logic [RCFR_RW-1:0] x, input int num);
		logic [63:0] p;
		p = 64'(x) * 64'(num);
		return RCFR_RW'(p / 64'(RATE_DEN));
	endfunction: rcfr_scale

	// moves cur a ramp step toward tgt from either side
	function automatic logic [RCFR_RW-1:0] rcfr_ramp(
		input logic [RCFR_RW-1:0] cur, input logic [RCFR_RW-1:0] tgt);
		if (tgt >= cur)
			return cur + RCFR_RW'((tgt - cur) / RCFR_RW'(RAMP_COEF));
		return cur - RCFR_RW'((cur - tgt) / RCFR_RW'(RAMP_COEF));
	endfunction: rcfr_ramp
endpackage: rcfr_pkg

// >>> rtl/rcfr_rate_chan.sv
// one byte-rate channel: raw counter with aging plus low-pass filter
module rcfr_rate_chan import rcfr_pkg::*; #(
	parameter int W = RCFR_RW
) (
	// clock and reset
	input logic sys_clk,
	input logic rstn,
	input logic clkEn,
	// events
	input logic [RCFR_IW-1:0] incr,
	input logic tick,
	// results
	output logic [W-1:0] rawCount,
	output logic [W-1:0] filtRate,
	output logic [W-1:0] filtNext
);
	typedef struct packed {
		logic [W-1:0] raw;
		logic [W-1:0] filt;
	} rcfr_chan_s;
	rcfr_chan_s q, d;
	logic [W+7:0] lpWide, ageWide;

	always_comb begin
		d = q;
		lpWide = ((W+8)'(q.filt) * (W+8)'(LP_COEF - 1) + (W+8)'(q.raw))
			/ (W+8)'(LP_COEF);
		ageWide = (W+8)'(q.raw) * (W+8)'(AGE_COEF - 1)
			/ (W+8)'(AGE_COEF);
		filtNext = W'(lpWide);
		// a byte arriving with the tick is added after aging, never lost
		if (tick) begin
			d.filt = W'(lpWide);
			d.raw = W'(ageWide) + W'(incr);
		end else
			d.raw = q.raw + W'(incr);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			q <= '0;
		else if (clkEn)
			q <= d;
	end

	assign rawCount = q.raw;
	assign filtRate = q.filt;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	filter_step_a: assert property (clkEn && tick |=> q.filt ==
		W'(((W+8)'($past(q.filt)) * (W+8)'(LP_COEF - 1)
		+ (W+8)'($past(q.raw))) / (W+8)'(LP_COEF)))
		else $error("filtered rate step wrong");
	count_step_a: assert property (rstn && clkEn && !tick |=>
		q.raw == $past(q.raw) + W'($past(incr)))
		else $error("raw byte count wrong");
endmodule: rcfr_rate_chan

// >>> tb/rcfr_mac_model.sv
// model of the mac data path that feeds byte events to the block
module rcfr_mac_model (
	// clock
	input logic sys_clk,
	// burst request from the bench
	input logic go,
	input logic [15:0] nAdd,
	output logic busy,
	// byte events toward the block
	output logic byteAdded,
	output logic byteForwarded,
	output logic beyondCongestion,
	output logic nonA0Byte
);
	timeunit 1ns;
	timeprecision 1ps;
	int left = 0;
	int seed = 71033;
	assign busy = (left != 0) || byteAdded;
	initial begin
		byteAdded = 1'b0;
		byteForwarded = 1'b0;
		beyondCongestion = 1'b0;
		nonA0Byte = 1'b0;
	end
	// one added byte a cycle until the burst is spent
	always @(posedge sys_clk) begin
		if (go)
			left <= int'(nAdd);
		else if (left != 0)
			left <= left - 1;
		byteAdded <= !go && (left != 0);
		// light forwarding keeps byte rates far below the rate thresholds
		byteForwarded <= 3'($random(seed)) == 3'h0;
		beyondCongestion <= 1'($random(seed));
		nonA0Byte <= 1'($random(seed));
	end
endmodule: rcfr_mac_model

// >>> tb/tb.sv
// self-checking bench of the ring fairness rate block
module tb import rcfr_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// signals
	// ****
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] avsAddress = 8'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	logic conservativeMode = 1'b0;
	logic oneQueueVariant = 1'b0;
	logic byteAdded, byteForwarded, beyondCongestion, nonA0Byte;
	logic [15:0] transitQueueDepth = 16'h0;
	logic classBDelayExpired = 1'b0;
	logic classCDelayExpired = 1'b0;
	logic agingTick = 1'b0;
	logic [15:0] advertisedFairRate = 16'hffff;
	logic [15:0] activeStationCount = 16'h1;
	logic localCongestionFlag;
	logic [31:0] ownFairRate, scaledOwnFairRate, permittedRate;
	logic [31:0] permittedRateTowardCongestion, scaledFilteredFwdCongRate;
	logic go = 1'b0;
	logic [15:0] nAdd = 16'h0;
	logic macBusy;
	logic [31:0] rdat, unres, ownExp, resv, permExp;
	logic [31:0] fwcRaw, fwcFilt;
	logic [31:0] towExp = 32'h0;
	logic [31:0] filtExp = 32'h0;
	logic [31:0] rawExp = 32'h0;
	int numErrors = 0;
	int compares = 0;
	int cycles = 0;
	int seed = 71033;
	int hits;
	logic [7:0] ofs [6] = '{OFS_LINE, OFS_RESV, OFS_STATION_A, OFS_QCAP,
		OFS_STATUS, 8'h40};
	logic [31:0] rv [6] = '{RST_LINE_RATE, RST_RESV_RATE, 32'(RST_STATION_A),
		32'(RST_QUEUE_CAP), 32'h1, 32'h0};

	always #2 sys_clk = ~sys_clk;

	rcfr_fair_rate rcfr_fair_rate_i (.sys_clk, .rstn, .clkEn(1'b1),
		.avsAddress, .avsRead, .avsWrite, .avsWritedata,
		.avsByteenable(4'hf), .avsReaddata, .avsWaitrequest,
		.conservativeMode, .oneQueueVariant, .byteAdded, .byteForwarded,
		.beyondCongestion, .nonA0Byte, .transitQueueDepth,
		.classBDelayExpired, .classCDelayExpired, .agingTick,
		.advertisedFairRate, .activeStationCount, .localCongestionFlag,
		.ownFairRate, .scaledOwnFairRate, .permittedRate,
		.permittedRateTowardCongestion, .scaledFilteredFwdCongRate);

	rcfr_mac_model rcfr_mac_model_i (.sys_clk, .go, .nAdd, .busy(macBusy),
		.byteAdded, .byteForwarded, .beyondCongestion, .nonA0Byte);

	// ****
	// helpers
	// ****
	// one ramp step toward the ceiling, from above or below
	function automatic logic [31:0] ramp(input logic [31:0] c);
		if (c > RATE_CEILING)
			return c - (c - RATE_CEILING) / 32'(RAMP_COEF);
		return c + (RATE_CEILING - c) / 32'(RAMP_COEF);
	endfunction: ramp

	function automatic logic [31:0] towNext(input logic [15:0] a,
		input logic [31:0] c);
		if (a != FULL_RATE_CODE)
			return 32'(a) * 32'(NORM_COEF);
		return ramp(c);
	endfunction: towNext

	function automatic logic [31:0] lowPass(input logic [31:0] f,
		input logic [31:0] r);
		return 32'((64'(f) * 64'(LP_COEF - 1) + 64'(r)) / 64'(LP_COEF));
	endfunction: lowPass

	task automatic printVerdict();
		$display("compares %0d mismatches %0d", compares, numErrors);
		if (numErrors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask: printVerdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			numErrors++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask: chk

	// request held until the edge that samples waitrequest low
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		avsAddress <= a;
		avsWritedata <= d;
		avsRead <= !wr;
		avsWrite <= wr;
		@(posedge sys_clk);
		while (avsWaitrequest !== 1'b0)
			@(posedge sys_clk);
		rdat = avsReaddata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge sys_clk);
	endtask: bus

	// one aging pulse; the model follows the filters and raw counts
	task automatic tick();
		agingTick <= 1'b1;
		@(posedge sys_clk);
		agingTick <= 1'b0;
		towExp = towNext(advertisedFairRate, towExp);
		filtExp = lowPass(filtExp, rawExp);
		rawExp = rawExp * 32'(AGE_COEF - 1) / 32'(AGE_COEF);
		@(posedge sys_clk);
		chk(permittedRateTowardCongestion, towExp);
		chk(scaledFilteredFwdCongRate, fwcFilt / 32'(NORM_COEF));
	endtask: tick

	task automatic chkOwn(input logic f);
		chk(32'(localCongestionFlag), 32'(f));
		chk(ownFairRate, ownExp);
		chk(scaledOwnFairRate, ownExp / 32'(NORM_COEF));
	endtask: chkOwn

	task automatic burst(input logic [15:0] n);
		nAdd <= n;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		@(posedge sys_clk);
		while (macBusy)
			@(posedge sys_clk);
		rawExp = rawExp + 32'(n);
	endtask: burst

	// rate changes at most once in nine ticks: one round trip is needed
	// the move is due on tick number at of the phase
	task automatic rttPhase(input logic up, input int at);
		hits = 0;
		for (int i = 0; i < 10; i++) begin
			tick();
			if (ownFairRate !== ownExp)
				hits++;
			if (i == at)
				ownExp = up ? ownExp + (unres - ownExp) / 32'(RAMP_COEF)
					: ownExp - ownExp / 32'(RAMP_COEF);
			chkOwn(1'b1);
			chk(permittedRate, ownExp);
		end
		chk(32'(hits), 32'h1);
	endtask: rttPhase

	// forward-beyond-congestion byte count and its filter, from the rules
	always @(posedge sys_clk) begin
		if (!rstn) begin
			fwcRaw <= 32'h0;
			fwcFilt <= 32'h0;
		end else if (agingTick) begin
			fwcFilt <= lowPass(fwcFilt, fwcRaw);
			fwcRaw <= fwcRaw * 32'(AGE_COEF - 1) / 32'(AGE_COEF)
				+ 32'(byteForwarded && beyondCongestion);
		end else
			fwcRaw <= fwcRaw + 32'(byteForwarded && beyondCongestion);
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			numErrors++;
			printVerdict();
		end
	end

	// ****
	// tests
	// ****
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ofs[i], 32'h0);
			chk(rdat, rv[i]);
		end
		$display("test registers finished");
		resv = 32'($random(seed)) & 32'h0003_ffff;
		unres = RST_LINE_RATE - resv;
		bus(1'b1, OFS_RESV, resv);
		bus(1'b1, OFS_CTRL, 32'h1);
		bus(1'b1, OFS_OWN, 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rdat, 32'h2);
		bus(1'b0, OFS_OWN, 32'h0);
		chk(rdat, unres);
		ownExp = unres;
		chkOwn(1'b0);
		chk(permittedRate, RATE_CEILING);
		$display("test init finished");
		for (int i = 0; i < 6; i++) begin
			advertisedFairRate <= (i < 3) ? 16'($random(seed)) & 16'h7fff
				: FULL_RATE_CODE;
			tick();
			chkOwn(1'b0);
		end
		$display("test calm ticks finished");
		// depth exactly at the low threshold is not congestion
		transitQueueDepth <= 16'(RST_QUEUE_CAP / Q_LO_DIV);
		tick();
		chkOwn(1'b0);
		for (int i = 0; i < 4; i++) begin
			burst(16'(100 + ($random(seed) & 255)));
			transitQueueDepth <= 16'(RST_QUEUE_CAP / Q_LO_DIV + 1);
			ownExp = filtExp;
			tick();
			chkOwn(1'b1);
		end
		transitQueueDepth <= 16'h0;
		ownExp = unres;
		tick();
		chkOwn(1'b0);
		$display("test aggressive finished");
		bus(1'b1, OFS_CTRL, 32'h0);
		oneQueueVariant <= 1'b1;
		advertisedFairRate <= 16'h1234;
		bus(1'b1, OFS_CTRL, 32'h1);
		for (int i = 0; i < 2; i++) begin
			classBDelayExpired <= (i == 0);
			classCDelayExpired <= (i == 1);
			tick();
			chk(32'(localCongestionFlag), 32'h1);
			classBDelayExpired <= 1'b0;
			classCDelayExpired <= 1'b0;
			tick();
			chk(32'(localCongestionFlag), 32'h0);
		end
		$display("test one queue finished");
		bus(1'b1, OFS_CTRL, 32'h0);
		oneQueueVariant <= 1'b0;
		conservativeMode <= 1'b1;
		activeStationCount <= 16'(3 + ($random(seed) & 3));
		bus(1'b1, OFS_STATION_A, 32'h2);
		bus(1'b1, OFS_CTRL, 32'h1);
		// a count change can take two full divisions to reach the share
		repeat (70) @(posedge sys_clk);
		transitQueueDepth <= 16'(RST_QUEUE_CAP / Q_HI_DIV + 1);
		tick();
		ownExp = (unres / 32'(activeStationCount)) * 32'h2;
		chkOwn(1'b1);
		chk(permittedRate, ownExp);
		rttPhase(1'b0, 8);
		transitQueueDepth <= 16'h0;
		rttPhase(1'b1, 7);
		// station_a above the station count lifts the share past unreserved
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, OFS_STATION_A, 32'(activeStationCount) + 32'h1);
		bus(1'b1, OFS_CTRL, 32'h1);
		transitQueueDepth <= 16'(RST_QUEUE_CAP / Q_HI_DIV + 1);
		tick();
		ownExp = (unres / 32'(activeStationCount))
			* (32'(activeStationCount) + 32'h1);
		chkOwn(1'b1);
		permExp = ownExp;
		transitQueueDepth <= 16'h0;
		for (int i = 0; i < 2; i++) begin
			tick();
			ownExp = unres;
			permExp = ramp(permExp);
			chkOwn(1'b0);
			chk(permittedRate, permExp);
		end
		$display("test conservative finished");
		printVerdict();
	end
endmodule: tb
